/* File: qdd_fault_diag.sv */
// Quad low-side driver protection, fault storage and serial readout
// What this block does
// R01: Overcurrent or overtemp latches channel off
// R02: Battery short outranks ground short, open load
// R03: Battery short from overcurrent or overtemperature
// R04: Open load: low current while on, filtered
// R05: Ground short: low drain while off
// R06: Each channel has independent thermal shutdown
// R07: Failures stored per channel, readable serially
// R08: Short control periods record no failure
// R09: First shift bit high when any failure
// R10: Select falling puts first bit out
// R11: Serial output tristate while select high
// R12: Next bit out on clock rising
// R13: Serial input captured on clock falling
// R14: First clock pulse clears failure register
// R15: Host keeps clock low around select
// R16: Select spikes cause no bus collision
// R17: Low supply forces stages off, clears
// R18: Reset pin forces stages off, clears
// R19: Low supply keeps channels off regardless
// R20: One dedicated control input per channel
// R21: Diagnostic filters need 140 to 250us
// R22: Select pulses up to 40ns ignored
// R23: Channel failures packed into one byte, ch1 low bit dropped
// R24: Only highest priority code per channel
// R25: Serial input affects nothing but shifter
`timescale 1ns/1ps
`default_nettype none
`include "qdd_params.svh"
module qdd_fault_diag #(
	parameter int unsigned DIAG_FILT_CYC = `QDD_DIAG_FILT_CYC,
	parameter int unsigned OC_FILT_CYC   = `QDD_OC_FILT_CYC
) (
	// Clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	// Channel control, active low per channel
	input  wire logic [3:0]  ctrl_n_in,
	// Analog comparator results per channel
	input  wire logic [3:0]  overcurrent_in,
	input  wire logic [3:0]  overtemp_in,
	input  wire logic [3:0]  below_open_load_ref_in,
	input  wire logic [3:0]  drain_below_ref_in,
	// Supply and reset
	input  wire logic        supply_low_in,
	input  wire logic        hw_reset_n_in,
	// Serial link
	input  wire logic        select_n_in,
	input  wire logic        sclk_in,
	input  wire logic        sdi_in,
	output logic             sdo_out,
	output logic             sdo_oe_out,
	// Power stage gates and status
	output logic [3:0]       stage_on_out,
	output logic [7:0]       fail_byte_out
);
	localparam int unsigned SEL_FILT_CYC = `QDD_SEL_FILT_CYC;
	localparam int unsigned SYNC_W = 20;

	qdd_link_if link ();

	////////////////////////////////////////////////////////////////////////////
	// Input synchronisers

	logic [SYNC_W-1:0] sync1;
	logic [SYNC_W-1:0] sync2;
	logic [SYNC_W-1:0] next_sync1;
	logic [SYNC_W-1:0] next_sync2;
	wire  [SYNC_W-1:0] raw = {ctrl_n_in, overcurrent_in, overtemp_in,
		below_open_load_ref_in, drain_below_ref_in};
	logic [3:0]        s_ctrl_n;
	logic [3:0]        s_oc;
	logic [3:0]        s_ot;
	logic [3:0]        s_ol;
	logic [3:0]        s_gnd;
	logic [1:0]        pwr1;
	logic [1:0]        pwr2;
	logic [1:0]        next_pwr1;
	logic [1:0]        next_pwr2;
	logic [2:0]        ser1;
	logic [2:0]        ser2;
	logic [2:0]        next_ser1;
	logic [2:0]        next_ser2;

	// Every pin but sys_clk_in and rst_in passes two flops before any logic reads it
	always_comb begin
		next_sync1 = raw;
		next_sync2 = sync1;
		next_pwr1  = {hw_reset_n_in, supply_low_in};
		next_pwr2  = pwr1;
		next_ser1  = {select_n_in, sclk_in, sdi_in};
		next_ser2  = ser1;
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			// Controls idle off and the reset request stands until synced
			sync1 <= {4'hF, 16'h0000};
			sync2 <= {4'hF, 16'h0000};
			pwr1  <= 2'h0;
			pwr2  <= 2'h0;
			ser1  <= 3'h4;
			ser2  <= 3'h4;
		end else begin
			sync1 <= next_sync1;
			sync2 <= next_sync2;
			pwr1  <= next_pwr1;
			pwr2  <= next_pwr2;
			ser1  <= next_ser1;
			ser2  <= next_ser2;
		end
	end

	assign {s_ctrl_n, s_oc, s_ot, s_ol, s_gnd} = sync2;
	wire hold_rst = ~pwr2[1] | pwr2[0]; // [R17] [R18] [R19]

	////////////////////////////////////////////////////////////////////////////
	// Select glitch filter and serial clock edges

	logic       sel_f;
	logic       next_sel_f;
	logic [3:0] sel_cnt;
	logic [3:0] next_sel_cnt;
	logic       sclk_d;
	logic       next_sclk_d;

	// A new select level must outlast the filter before it counts
	always_comb begin
		next_sel_f   = sel_f;
		next_sel_cnt = 4'h0;
		next_sclk_d  = ser2[1];
		if (ser2[2] != sel_f) begin
			next_sel_cnt = sel_cnt + 4'h1;
			if (sel_cnt >= 4'(SEL_FILT_CYC)) begin
				next_sel_f   = ser2[2]; // [R22] [R16]
				next_sel_cnt = 4'h0;
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			sel_f   <= 1'b1;
			sel_cnt <= 4'h0;
			sclk_d  <= 1'b0;
		end else begin
			sel_f   <= next_sel_f;
			sel_cnt <= next_sel_cnt;
			sclk_d  <= next_sclk_d;
		end
	end

	// Serial clock edges as seen by the system clock
	assign link.sel_active = ~sel_f;
	assign link.sclk_rise  = ser2[1] & ~sclk_d;
	assign link.sclk_fall  = ~ser2[1] & sclk_d;
	assign link.sdi        = ser2[0];

	////////////////////////////////////////////////////////////////////////////
	// Per-channel protection and failure storage

	function automatic qdd_pkg::qdd_code_t rank(input qdd_pkg::qdd_code_t a,
		input qdd_pkg::qdd_code_t b);
		rank = (a > b) ? a : b; // [R02] [R24]
	endfunction

	logic [3:0]              latched_off;
	logic [3:0]              next_latched_off;
	logic [3:0]              ctrl_d;
	logic [3:0]              next_ctrl_d;
	logic [3:0]              stage_on;
	logic [3:0]              next_stage_on;
	logic [15:0]             oc_cnt [4];
	logic [15:0]             next_oc_cnt [4];
	logic [15:0]             dg_cnt [4];
	logic [15:0]             next_dg_cnt [4];
	qdd_pkg::qdd_code_t      code [4];
	qdd_pkg::qdd_code_t      next_code [4];
	qdd_pkg::qdd_byte_t      fail_byte;

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			logic on_req;
			logic trip;
			logic cond;
			qdd_pkg::qdd_code_t hit;
			on_req = ~s_ctrl_n[i]; // [R20]
			next_ctrl_d[i] = on_req;
			next_latched_off[i] = latched_off[i];
			next_oc_cnt[i] = 16'h0;
			next_dg_cnt[i] = 16'h0;
			next_code[i]   = code[i];
			hit  = `QDD_CODE_NONE;
			trip = 1'b0;
			// Overcurrent must outlast its filter, overtemp trips at once
			if (on_req && s_oc[i]) begin
				next_oc_cnt[i] = oc_cnt[i] + 16'h1;
				if (oc_cnt[i] >= 16'(OC_FILT_CYC)) begin
					// Counter holds here so it never wraps back below the limit
					next_oc_cnt[i] = oc_cnt[i];
					trip           = 1'b1; // [R01]
				end
			end
			if (on_req && s_ot[i])
				trip = 1'b1; // [R06]
			if (trip) begin
				next_latched_off[i] = 1'b1; // [R01]
				hit = `QDD_CODE_SCB; // [R03]
			end
			if (ctrl_d[i] && !on_req)
				next_latched_off[i] = 1'b0; // [R01]
			// Filter counter restarts when the control level changes
			cond = (on_req == ctrl_d[i]) && (on_req ? s_ol[i] : s_gnd[i]);
			if (cond) begin
				next_dg_cnt[i] = dg_cnt[i];
				if (dg_cnt[i] >= 16'(DIAG_FILT_CYC))
					hit = rank(hit, on_req ? `QDD_CODE_OL : `QDD_CODE_SCG); // [R04] [R05] [R21] [R08]
				else
					next_dg_cnt[i] = dg_cnt[i] + 16'h1;
			end
			// A new failure wins over a clear in the same cycle
			if (link.clear_req)
				next_code[i] = `QDD_CODE_NONE; // [R14]
			next_code[i] = rank(next_code[i], hit); // [R07]
			next_stage_on[i] = on_req & ~next_latched_off[i] & ~trip;
		end
		// Reset pin or low supply clears stages, latches, filters and failures
		if (hold_rst) begin
			next_stage_on    = 4'h0; // [R17] [R18] [R19]
			next_latched_off = 4'h0;
			for (int i = 0; i < 4; i++) begin
				next_oc_cnt[i] = 16'h0;
				next_dg_cnt[i] = 16'h0;
				next_code[i]   = `QDD_CODE_NONE;
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			latched_off <= 4'h0;
			ctrl_d      <= 4'h0;
			stage_on    <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				oc_cnt[i] <= 16'h0;
				dg_cnt[i] <= 16'h0;
				code[i]   <= `QDD_CODE_NONE;
			end
		end else begin
			latched_off <= next_latched_off;
			ctrl_d      <= next_ctrl_d;
			stage_on    <= next_stage_on;
			for (int i = 0; i < 4; i++) begin
				oc_cnt[i] <= next_oc_cnt[i];
				dg_cnt[i] <= next_dg_cnt[i];
				code[i]   <= next_code[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Failure byte: flag bit, then channels 4..2 codes, channel 1 partial

	always_comb begin
		logic any;
		any = 1'b0;
		for (int i = 0; i < 4; i++)
			any = any | (code[i] != `QDD_CODE_NONE);
		// Bit 7 flag, bits 6:0 hold channel codes 4..1 (ch1 low bit dropped)
		fail_byte = {any, code[3], code[2], code[1], code[0][1]}; // [R09] [R23]
	end

	assign link.fail_byte = fail_byte;

	////////////////////////////////////////////////////////////////////////////
	// Serial shifter and registered outputs

	qdd_shifter u_shifter (
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.link       (link),
		.sdo_out    (sdo_out),
		.sdo_oe_out (sdo_oe_out)
	);

	qdd_pkg::qdd_byte_t fail_q;
	qdd_pkg::qdd_byte_t next_fail_q;

	// Failure byte output comes from its own flop
	always_comb begin
		next_fail_q = fail_byte;
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in)
			fail_q <= 8'h00;
		else
			fail_q <= next_fail_q;
	end

	assign stage_on_out  = stage_on;
	assign fail_byte_out = fail_q;
endmodule // qdd_fault_diag
`default_nettype wire

/* File: qdd_fault_diag_monitor.sv */
// Assertion checker for the fault diagnosis block
`timescale 1ns/1ps
`default_nettype none
module qdd_fault_diag_monitor (
	// Clock and reset
	input wire logic       sys_clk_in,
	input wire logic       rst_in,
	// Watched inputs
	input wire logic [3:0] overtemp_in,
	input wire logic       supply_low_in,
	input wire logic       hw_reset_n_in,
	input wire logic       select_n_in,
	input wire logic       sclk_in,
	// Watched outputs
	input wire logic       sdo_out,
	input wire logic       sdo_oe_out,
	input wire logic [3:0] stage_on_out,
	input wire logic [7:0] fail_byte_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	chk_pin_reset: assert property (
		(!hw_reset_n_in)[*6] |-> stage_on_out == 4'h0 && fail_byte_out == 8'h00)
		else $error("reset pin left stages or failures");
	chk_low_supply: assert property (
		supply_low_in[*6] |-> stage_on_out == 4'h0 && fail_byte_out == 8'h00)
		else $error("low supply left stages or failures");
	chk_oe_idle: assert property (
		select_n_in[*8] |-> !sdo_oe_out)
		else $error("serial output driven while deselected");
	chk_spike_quiet: assert property (
		select_n_in[*8] ##1 !select_n_in ##1 select_n_in |-> (!sdo_oe_out)[*8])
		else $error("select spike enabled serial output");
	chk_first_bit: assert property (
		$fell(select_n_in) ##1 (!select_n_in && !sclk_in)[*7]
		|-> sdo_oe_out && sdo_out == fail_byte_out[7])
		else $error("first bit not driven after select");
	chk_flag_bit: assert property (
		fail_byte_out[6:0] != 7'h00 |-> fail_byte_out[7])
		else $error("failure flag bit low");
	chk_thermal_off: assert property (
		overtemp_in[3][*6] |-> !stage_on_out[3])
		else $error("hot channel still on");
	chk_sdo_steady: assert property (
		(sdo_oe_out && !sclk_in)[*5] |-> $stable(sdo_out))
		else $error("serial output moved without clock rise");
endmodule // qdd_fault_diag_monitor
bind qdd_fault_diag qdd_fault_diag_monitor i_qdd_fault_diag_monitor (.sys_clk_in, .rst_in,
	.overtemp_in, .supply_low_in, .hw_reset_n_in, .select_n_in, .sclk_in, .sdo_out,
	.sdo_oe_out, .stage_on_out, .fail_byte_out);
`default_nettype wire

/* File: qdd_fault_diag_tb_top.sv */
// Self-checking bench for the fault diagnosis block
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin checks++; if ((got) !== (exp)) begin num_errors++; \
	$display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp); end end
module qdd_fault_diag_tb_top;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] ctrl_n = 4'hF;
	logic [3:0] ocur = 4'h0;
	logic [3:0] otemp = 4'h0;
	logic [3:0] low_cur = 4'h0;
	logic [3:0] low_drain = 4'h0;
	logic supply_low = 1'b0;
	logic hw_reset_n = 1'b1;
	wire logic select_n, sclk, sdi, sdo, sdo_oe;
	wire logic [3:0] stage_on;
	wire logic [7:0] fail_byte;
	logic [7:0] rx;
	int num_errors = 0;
	int checks = 0;
	qdd_fault_diag #(.DIAG_FILT_CYC(20), .OC_FILT_CYC(3)) i_qdd_fault_diag (
		.sys_clk_in(sys_clk), .rst_in(rst), .ctrl_n_in(ctrl_n), .overcurrent_in(ocur),
		.overtemp_in(otemp), .below_open_load_ref_in(low_cur), .drain_below_ref_in(low_drain),
		.supply_low_in(supply_low), .hw_reset_n_in(hw_reset_n), .select_n_in(select_n),
		.sclk_in(sclk), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
		.stage_on_out(stage_on), .fail_byte_out(fail_byte));
	qdd_host_model i_qdd_host_model (.sys_clk_in(sys_clk), .sdo_in(sdo), .sdo_oe_in(sdo_oe),
		.select_n_out(select_n), .sclk_out(sclk), .sdi_out(sdi));
	initial forever #20 sys_clk = ~sys_clk;
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic read_exp(input logic [7:0] exp);
		i_qdd_host_model.xfer(8'hFF, rx);
		`CHECK(rx, exp)
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		wait_cyc(16);
		rst <= 1'b0;
		wait_cyc(8);
		// Open load on channel 2
		ctrl_n <= 4'hD;
		low_cur <= 4'h2;
		wait_cyc(40);
		`CHECK(stage_on, 4'h2)
		`CHECK(fail_byte, 8'h82)
		low_cur <= 4'h0;
		read_exp(8'h82);
		`CHECK(stage_on, 4'h2)
		read_exp(8'h00);
		// Overcurrent, ground short and overtemp with low current together
		ctrl_n <= 4'h4;
		ocur <= 4'h1;
		otemp <= 4'h8;
		low_drain <= 4'h4;
		low_cur <= 4'h8;
		wait_cyc(40);
		`CHECK(stage_on, 4'h2)
		`CHECK(fail_byte, 8'hF1)
		ocur <= 4'h0;
		otemp <= 4'h0;
		low_drain <= 4'h0;
		low_cur <= 4'h0;
		wait_cyc(10);
		`CHECK(stage_on, 4'h2)
		ctrl_n <= 4'hF;
		wait_cyc(10);
		ctrl_n <= 4'h4;
		wait_cyc(10);
		`CHECK(stage_on, 4'hB)
		read_exp(8'hF1);
		read_exp(8'h00);
		// Control periods shorter than the filter
		low_cur <= 4'h1;
		low_drain <= 4'h1;
		repeat (6) begin
			ctrl_n <= 4'hE;
			wait_cyc(10);
			ctrl_n <= 4'hF;
			wait_cyc(10);
		end
		low_cur <= 4'h0;
		low_drain <= 4'h0;
		`CHECK(fail_byte, 8'h00)
		// Select glitch
		i_qdd_host_model.spike();
		repeat (8) begin
			wait_cyc(1);
			`CHECK(sdo_oe, 1'b0)
		end
		// Reset pin, then low supply
		for (int k = 0; k < 2; k++) begin
			ctrl_n <= 4'h0;
			low_cur <= 4'hF;
			wait_cyc(40);
			`CHECK(fail_byte, 8'hAA)
			hw_reset_n <= (k != 0);
			supply_low <= (k != 0);
			wait_cyc(8);
			`CHECK(stage_on, 4'h0)
			`CHECK(fail_byte, 8'h00)
			low_cur <= 4'h0;
			ctrl_n <= 4'hF;
			hw_reset_n <= 1'b1;
			supply_low <= 1'b0;
			wait_cyc(8);
		end
		end_of_test();
	end
	initial begin
		wait_cyc(5000);
		num_errors++;
		end_of_test();
	end
endmodule // qdd_fault_diag_tb_top
`default_nettype wire

/* File: qdd_host_model.sv */
// Host serial master model for the diagnostic link
`timescale 1ns/1ps
`default_nettype none
module qdd_host_model (
	// Clock and serial data back
	input  wire logic sys_clk_in,
	input  wire logic sdo_in,
	input  wire logic sdo_oe_in,
	// Serial link out
	output var  logic select_n_out,
	output var  logic sclk_out,
	output var  logic sdi_out
);
	logic last = 1'b0;
	wire logic line;
	initial begin
		select_n_out = 1'b1;
		sclk_out = 1'b0;
		sdi_out = 1'b0;
	end
	// Released line shows the inverse of its last driven bit
	always @(posedge sys_clk_in) if (sdo_oe_in) last <= sdo_in;
	assign line = sdo_oe_in ? sdo_in : ~last;
	// 320 ns link clock, low at every select change
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		select_n_out <= 1'b0;
		repeat (12) @(posedge sys_clk_in);
		for (int i = 7; i >= 0; i--) begin
			rx[i] = line;
			sdi_out <= tx[i];
			repeat (2) @(posedge sys_clk_in);
			sclk_out <= 1'b1;
			repeat (4) @(posedge sys_clk_in);
			sclk_out <= 1'b0;
			repeat (2) @(posedge sys_clk_in);
		end
		// Clock stays low a while before select rises
		repeat (2) @(posedge sys_clk_in);
		select_n_out <= 1'b1;
		repeat (12) @(posedge sys_clk_in);
	endtask
	// One cycle select glitch, clock held low
	task automatic spike();
		select_n_out <= 1'b0;
		@(posedge sys_clk_in);
		select_n_out <= 1'b1;
	endtask
endmodule // qdd_host_model
`default_nettype wire

/* File: qdd_link_if.sv */
// Signals between the fault core and the serial shifter
`timescale 1ns/1ps
`default_nettype none
interface qdd_link_if;
	logic                 sel_active;
	logic                 sclk_rise;
	logic                 sclk_fall;
	logic                 sdi;
	qdd_pkg::qdd_byte_t   fail_byte;
	logic                 clear_req;
	modport core (output sel_active, sclk_rise, sclk_fall, sdi, fail_byte, input clear_req);
	modport shifter (input sel_active, sclk_rise, sclk_fall, sdi, fail_byte, output clear_req);
endinterface
`default_nettype wire

/* File: qdd_params.svh */
// Constants for the quad driver fault diagnosis block
`ifndef QDD_PARAMS_SVH
`define QDD_PARAMS_SVH

`define QDD_CLK_HZ          25000000
`define QDD_NUM_CH          4
// Diagnostic filter time, least 140 us (most 250 us)
`define QDD_DIAG_FILT_US    140
`define QDD_DIAG_FILT_CYC   ((`QDD_DIAG_FILT_US * (`QDD_CLK_HZ / 1000000)))
// Select glitch filter, pulses up to 40 ns ignored
`define QDD_SEL_FILT_NS     40
`define QDD_SEL_FILT_CYC    (((`QDD_SEL_FILT_NS * (`QDD_CLK_HZ / 1000000)) + 999) / 1000)
// Overcurrent filter time, parameter default in cycles
`define QDD_OC_FILT_CYC     25
// Failure codes per two-bit channel field
`define QDD_CODE_NONE       2'h0
`define QDD_CODE_OL         2'h1
`define QDD_CODE_SCG        2'h2
`define QDD_CODE_SCB        2'h3

`endif

/* File: qdd_pkg.sv */
// Types for the quad driver fault diagnosis block
package qdd_pkg;
	typedef logic [1:0] qdd_code_t;
	typedef logic [7:0] qdd_byte_t;
	typedef enum logic [1:0] {QDD_IDLE, QDD_ACTIVE} qdd_link_e;
endpackage

/* File: qdd_shifter.sv */
// Diagnostic shift register driven from the serial link
`timescale 1ns/1ps
`default_nettype none
`include "qdd_params.svh"
module qdd_shifter (
	// Clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	// Link to core
	qdd_link_if.shifter      link,
	// Serial data out
	output logic             sdo_out,
	output logic             sdo_oe_out
);
	qdd_pkg::qdd_byte_t shreg;
	qdd_pkg::qdd_byte_t next_shreg;
	logic               first;
	logic               next_first;
	logic               sdo;
	logic               next_sdo;
	logic               oe;
	logic               next_oe;
	logic               prev_active;
	logic               clr;
	logic               next_clr;

	always_comb begin
		next_shreg = shreg;
		next_first = first;
		next_sdo   = sdo;
		next_oe    = link.sel_active; // [R11] [R16]
		next_clr   = 1'b0;
		if (link.sel_active && !prev_active) begin
			next_shreg = link.fail_byte;
			next_sdo   = link.fail_byte[7]; // [R10]
			next_first = 1'b1;
		end else if (link.sel_active) begin
			if (link.sclk_rise) begin
				// Bit 7 left at select, so each rise shows the bit behind it
				next_sdo = shreg[6]; // [R12]
				if (first) begin
					next_clr   = 1'b1; // [R14]
					next_first = 1'b0;
				end
			end
			if (link.sclk_fall)
				next_shreg = {shreg[6:0], link.sdi}; // [R13] [R25]
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			shreg       <= 8'h00;
			first       <= 1'b0;
			sdo         <= 1'b0;
			oe          <= 1'b0;
			prev_active <= 1'b0;
			clr         <= 1'b0;
		end else begin
			shreg       <= next_shreg;
			first       <= next_first;
			sdo         <= next_sdo;
			oe          <= next_oe;
			prev_active <= link.sel_active;
			clr         <= next_clr;
		end
	end

	assign link.clear_req = clr;
	assign sdo_out        = sdo;
	assign sdo_oe_out     = oe;
endmodule // qdd_shifter
`default_nettype wire
